// >>> rtl/lplpm_top.sv
// lplpm_top: low-power state tracking of a mobile DDR SDRAM
// assumes: clock pair and command pins arrive asynchronously and are
// synchronised here; clk runs at 10 MHz, well above the link clock
`timescale 1ns/1ps

module lplpm_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic diff_clock_true,
   input wire logic diff_clock_comp,
   input wire logic clock_enable_pin,
   input wire logic chip_select_n,
   input wire logic row_strobe_n,
   input wire logic column_strobe_n,
   input wire logic write_enable_n,
   input wire logic precharge_all_addr_bit,
   input wire logic [lplpm_pkg::BANK_BITS-1:0] bank_addr,
   input wire logic [lplpm_pkg::PASR_BITS-1:0] pasr_select,
   input wire logic [lplpm_pkg::TEMP_BITS-1:0] temp_sensor,
   output logic [2:0] lp_state,
   output logic input_buffers_on,
   output logic data_valid,
   output logic init_required,
   output logic refresh_pulse,
   output logic exit_busy,
   output logic cmd_violation
);
   localparam int NSYNC = 15;

   typedef struct packed {
      logic [1:0] rst_sync;
      logic [NSYNC-1:0] s1;
      logic [NSYNC-1:0] s2;
      logic lck_prev;
      logic [3:0] stop_cnt;
      lplpm_pkg::lplpm_state_e state;
      logic [lplpm_pkg::NUM_BANKS-1:0] open;
      logic [3:0] wait_cnt;
      logic [1:0] pulse_cnt;
      logic buf_on;
      logic valid;
      logic init_req;
      logic ref_pulse;
      logic busy_out;
      logic viol;
      logic [2:0] st_out;
      logic [lplpm_pkg::PASR_BITS-1:0] pasr;
   } lplpm_top_s;

   lplpm_top_s r;
   lplpm_top_s next_r;
   logic rst_n;
   lplpm_if rif ();

   // sampled pin copies, read only from the second stage
   logic lck;
   logic lckc;
   logic cke;
   logic all_bank;
   logic [3:0] cmd;
   logic [lplpm_pkg::BANK_BITS-1:0] bank_s;
   logic [lplpm_pkg::PASR_BITS-1:0] pasr_s;
   logic [lplpm_pkg::TEMP_BITS-1:0] temp_s;
   logic link_rise;
   logic nop;
   assign rst_n = r.rst_sync[1];
   // address and select levels ride the same two stages as the command
   assign {lck, lckc, cke, cmd, all_bank, bank_s, pasr_s, temp_s} = r.s2;
   assign link_rise = lck && !r.lck_prev && !lckc;
   assign nop = cmd[3] || (cmd == lplpm_pkg::CMD_NOP);

   lplpm_refresh u_refresh (
      .clk(clk),
      .rst_n(rst_n),
      .port(rif.sched)
   );

   assign rif.run = (r.state == lplpm_pkg::ST_SELF_REF);
   assign rif.pasr = r.pasr;
   assign rif.temp = temp_s;

   // ****************************************************************
   // state tracker
   // ****************************************************************
   always_comb begin
      next_r = r;
      next_r.rst_sync = {r.rst_sync[0], 1'b1};
      next_r.s1 = {diff_clock_true, diff_clock_comp, clock_enable_pin, chip_select_n,
         row_strobe_n, column_strobe_n, write_enable_n, precharge_all_addr_bit, bank_addr,
         pasr_select, temp_sensor};
      next_r.s2 = r.s1;
      next_r.lck_prev = lck;
      next_r.stop_cnt = 4'h0;
      next_r.ref_pulse = rif.tick;
      next_r.viol = 1'b0;
      unique case (r.state)
         lplpm_pkg::ST_IDLE, lplpm_pkg::ST_ACTIVE: begin
            if (link_rise) begin
               if (!cke && cmd == lplpm_pkg::CMD_REFRESH && r.open == '0) begin
                  next_r.state = lplpm_pkg::ST_SELF_REF;
                  next_r.pasr = pasr_s;
                  next_r.buf_on = 1'b0;
               end else if (!cke && cmd == lplpm_pkg::CMD_DEEP && r.open == '0) begin
                  next_r.state = lplpm_pkg::ST_DEEP;
                  next_r.valid = 1'b0;
                  next_r.init_req = 1'b1;
                  next_r.open = '0;
                  next_r.buf_on = 1'b0;
               end else if (!cke) begin
                  // bank state picks the flavour of power-down
                  next_r.state = (r.open == '0) ? lplpm_pkg::ST_PRE_PD
                     : lplpm_pkg::ST_ACT_PD;
                  next_r.buf_on = 1'b0;
               end else if (cmd == lplpm_pkg::CMD_ACTIVE) begin
                  next_r.open[bank_s] = 1'b1;
                  next_r.state = lplpm_pkg::ST_ACTIVE;
               end else if (cmd == lplpm_pkg::CMD_PRECHARGE) begin
                  if (all_bank) begin
                     next_r.open = '0;
                  end else begin
                     next_r.open[bank_s] = 1'b0;
                  end
               end else if (cmd == lplpm_pkg::CMD_MODE && r.init_req) begin
                  next_r.init_req = 1'b0; // mode load closes initialization
                  next_r.valid = 1'b1;
               end
               if (cke && !nop && r.busy_out) begin
                  next_r.viol = 1'b1;
               end
               if (r.busy_out && r.pulse_cnt != 2'h0) begin
                  next_r.pulse_cnt = r.pulse_cnt - 2'h1;
               end
            end
            if (r.wait_cnt != 4'h0) begin
               next_r.wait_cnt = r.wait_cnt - 4'h1;
            end
            if (r.wait_cnt <= 4'h1 && (r.pulse_cnt == 2'h0 || (link_rise
               && r.pulse_cnt == 2'h1))) begin
               next_r.busy_out = 1'b0;
            end
            if (next_r.state == lplpm_pkg::ST_IDLE || next_r.state == lplpm_pkg::ST_ACTIVE) begin
               next_r.state = (next_r.open == '0) ? lplpm_pkg::ST_IDLE
                  : lplpm_pkg::ST_ACTIVE;
            end
            // a low phase longer than any running link period means a parked
            // clock; a plain low half must not be taken for a stop
            next_r.stop_cnt = (!lck && lckc && r.stop_cnt != 4'hF) ? r.stop_cnt + 4'h1
               : ((!lck && lckc) ? r.stop_cnt : 4'h0);
            if (cke && r.stop_cnt >= 4'(lplpm_pkg::STOP_DETECT_CYCLES)) begin
               next_r.state = lplpm_pkg::ST_CLK_STOP;
            end
         end
         lplpm_pkg::ST_SELF_REF: begin
            // every input but clock enable and the scheduler busy is ignored here
            if (cke && !rif.busy) begin
               next_r.state = lplpm_pkg::ST_IDLE;
               next_r.busy_out = 1'b1;
               next_r.wait_cnt = 4'(lplpm_pkg::XSR_CYCLES);
               next_r.pulse_cnt = 2'(lplpm_pkg::XSR_MIN_PULSES);
               next_r.buf_on = 1'b1;
            end
         end
         lplpm_pkg::ST_PRE_PD, lplpm_pkg::ST_ACT_PD: begin
            // exit is synchronous: needs a clock edge with a NOP
            if (link_rise && cke && nop) begin
               next_r.state = (r.state == lplpm_pkg::ST_PRE_PD) ? lplpm_pkg::ST_IDLE
                  : lplpm_pkg::ST_ACTIVE;
               next_r.busy_out = 1'b1;
               next_r.pulse_cnt = 2'(lplpm_pkg::XP_LINK_PULSES);
               next_r.buf_on = 1'b1;
            end
         end
         lplpm_pkg::ST_DEEP: begin
            if (link_rise && cke && nop) begin
               next_r.state = lplpm_pkg::ST_IDLE;
               next_r.buf_on = 1'b1;
            end
         end
         lplpm_pkg::ST_CLK_STOP: begin
            // restart: first rising edge must carry a NOP
            if (link_rise) begin
               next_r.state = (r.open == '0) ? lplpm_pkg::ST_IDLE : lplpm_pkg::ST_ACTIVE;
               next_r.busy_out = 1'b1;
               next_r.pulse_cnt = 2'(lplpm_pkg::STOP_PULSES);
               next_r.viol = !nop;
            end
         end
         default: begin
            next_r.state = lplpm_pkg::ST_IDLE;
         end
      endcase
      next_r.st_out = 3'(next_r.state);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
         r.s1 <= '0;
         r.state <= lplpm_pkg::ST_IDLE;
         r.buf_on <= 1'b1;
         r.init_req <= 1'b1;
         r.pasr <= lplpm_pkg::PASR_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign lp_state = r.st_out;
   assign input_buffers_on = r.buf_on;
   assign data_valid = r.valid;
   assign init_required = r.init_req;
   assign refresh_pulse = r.ref_pulse;
   assign exit_busy = r.busy_out;
   assign cmd_violation = r.viol;

   // ****************************************************************
   // checks
   // ****************************************************************
   sr_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r.state == lplpm_pkg::ST_IDLE && link_rise && !cke && cmd == lplpm_pkg::CMD_REFRESH)
      |=> r.state == lplpm_pkg::ST_SELF_REF) else $error("self refresh not entered");
   sr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r.state == lplpm_pkg::ST_SELF_REF && !cke) |=> r.state == lplpm_pkg::ST_SELF_REF)
      else $error("self refresh left with clock enable low");
   pd_kind_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r.state == lplpm_pkg::ST_ACTIVE && link_rise && !cke && cmd == lplpm_pkg::CMD_NOP)
      |=> r.state == lplpm_pkg::ST_ACT_PD) else $error("wrong power-down kind");
   pd_buffers_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r.state == lplpm_pkg::ST_PRE_PD || r.state == lplpm_pkg::ST_ACT_PD) |-> !r.buf_on)
      else $error("buffers on in power-down");
   pd_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r.state == lplpm_pkg::ST_PRE_PD && link_rise && cke && nop)
      |=> r.state == lplpm_pkg::ST_IDLE && r.busy_out) else $error("power-down exit missed");
   deep_loss_a: assert property (@(posedge clk) disable iff (!rst_n)
      r.state == lplpm_pkg::ST_DEEP |-> !r.valid && r.init_req)
      else $error("data valid in deep sleep");
   deep_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r.state == lplpm_pkg::ST_IDLE && link_rise && !cke && cmd == lplpm_pkg::CMD_DEEP)
      |=> r.state == lplpm_pkg::ST_DEEP) else $error("deep sleep not entered");
   deep_stay_a: assert property (@(posedge clk) disable iff (!rst_n)
      (r.state == lplpm_pkg::ST_DEEP && !cke) |=> r.state == lplpm_pkg::ST_DEEP)
      else $error("deep sleep left early");

endmodule : lplpm_top

// >>> rtl/lplpm_pkg.sv
// lplpm_pkg: constants, states and commands of the low-power state tracker
// assumes: nothing beyond standard SystemVerilog
package lplpm_pkg;

   // ****************************************************************
   // command encodings {cs_n, ras_n, cas_n, we_n}
   // ****************************************************************
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [3:0] CMD_ACTIVE = 4'h3;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_MODE = 4'h0;
   localparam logic [3:0] CMD_TERMINATE = 4'h6;
   localparam logic [3:0] CMD_DEEP = 4'h6;

   // ****************************************************************
   // sizes and reset values
   // ****************************************************************
   localparam int NUM_BANKS = 4;
   localparam int BANK_BITS = 2;
   localparam int PASR_BITS = 3;
   localparam int TEMP_BITS = 2;
   localparam int RATE_BITS = 4;
   localparam logic [PASR_BITS-1:0] PASR_RESET = 3'h0;

   // ****************************************************************
   // timing: the link clock is sampled by the 10 MHz core clock
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int XSR_NS = 112;
   localparam int XSR_CYCLES = (XSR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int XSR_MIN_PULSES = 2;
   localparam int XP_LINK_PULSES = 1;
   localparam int STOP_PULSES = 1;
   // core clocks of unbroken low phase before the link clock counts as parked;
   // must exceed the longest low half of a running link clock
   localparam int STOP_DETECT_CYCLES = 12;
   localparam int REFRESH_SLOTS = 8;

   // ****************************************************************
   // low-power state
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE, ST_ACTIVE, ST_SELF_REF, ST_PRE_PD, ST_ACT_PD, ST_DEEP, ST_CLK_STOP
   } lplpm_state_e;

endpackage : lplpm_pkg

// >>> rtl/lplpm_if.sv
// lplpm_if: run, array portion and temperature from the state tracker to the refresh scheduler, tick and busy back
// assumes: both ends on clk
`timescale 1ns/1ps
interface lplpm_if;
   logic tick;        // one-cycle pulse per refresh slot inside the selected array portion
   logic busy;        // scheduler has an internal refresh in progress
   logic run;         // scheduler enabled (self refresh)
   logic [lplpm_pkg::PASR_BITS-1:0] pasr;
   logic [lplpm_pkg::TEMP_BITS-1:0] temp;
   modport ctrl (output run, output pasr, output temp, input tick, input busy);
   modport sched (input run, input pasr, input temp, output tick, output busy);
endinterface : lplpm_if

// >>> rtl/lplpm_refresh.sv
// lplpm_refresh: internal refresh scheduler for self refresh
// assumes: clk domain, reset already synchronised
`timescale 1ns/1ps
module lplpm_refresh (
   input wire logic clk,
   input wire logic rst_n,
   lplpm_if.sched port
);
   typedef struct packed {
      logic [lplpm_pkg::RATE_BITS-1:0] cnt;
      logic [2:0] slot;
      logic tick;
      logic busy;
   } lplpm_ref_s;

   lplpm_ref_s r;
   lplpm_ref_s next_r;
   logic [lplpm_pkg::RATE_BITS-1:0] period;

   // ****************************************************************
   // rate follows the sensor: hotter means a shorter period
   // ****************************************************************
   always_comb begin
      period = lplpm_pkg::RATE_BITS'(4'hF >> port.temp);
      next_r = r;
      next_r.tick = 1'b0;
      if (!port.run) begin
         next_r.cnt = '0;
         next_r.busy = 1'b0;
      end else if (r.cnt >= period) begin
         next_r.cnt = '0;
         next_r.slot = r.slot + 3'h1;
         // only slots inside the selected array portion are refreshed
         next_r.tick = (r.slot <= (3'h7 >> port.pasr));
         next_r.busy = next_r.tick;
      end else begin
         next_r.cnt = r.cnt + 4'h1;
         next_r.busy = r.busy && (r.cnt < 4'h1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign port.tick = r.tick;
   assign port.busy = r.busy;

   refresh_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
      !port.run |=> !port.tick) else $error("refresh tick outside self refresh");

endmodule : lplpm_refresh

// >>> sim/lplpm_ctrl_model.sv
// lplpm_ctrl_model: behavioural memory controller for the low-power state tracker
// assumes: the bench calls drive and halt; clk is the 10 MHz core clock
`timescale 1ns/1ps
module lplpm_ctrl_model (
   input wire logic clk,
   output logic diff_clock_true,
   output logic diff_clock_comp,
   output logic clock_enable_pin,
   output logic chip_select_n,
   output logic row_strobe_n,
   output logic column_strobe_n,
   output logic write_enable_n,
   output logic precharge_all_addr_bit
);
   // ****************************************************************
   // link pins
   // ****************************************************************
   // quiet start: pair parked low, enable high, command bus on NOP
   initial begin
      {diff_clock_true, diff_clock_comp} = 2'h1;
      clock_enable_pin = 1'b1;
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = lplpm_pkg::CMD_NOP;
      precharge_all_addr_bit = 1'b0;
   end

   // one link period of two halves of core clocks; pins settle in the low half
   // so the rising edge never meets a changing command
   task automatic drive(input logic [3:0] cmd, input logic ck_en, input logic all_bit,
      input int half = 4);
      @(posedge clk);
      #5;
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = cmd;
      clock_enable_pin = ck_en;
      precharge_all_addr_bit = all_bit;
      repeat (half) @(posedge clk);
      #5;
      {diff_clock_true, diff_clock_comp} = 2'h2;
      repeat (half) @(posedge clk);
      #5;
      {diff_clock_true, diff_clock_comp} = 2'h1;
   endtask : drive

   // clock stop: nothing pending, pair parked true low, complement high
   task automatic halt(input int cycles);
      @(posedge clk);
      #5;
      clock_enable_pin = 1'b1;
      {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = lplpm_pkg::CMD_NOP;
      repeat (cycles) @(posedge clk);
      #5;
   endtask : halt
endmodule : lplpm_ctrl_model

// >>> sim/lplpm_top_tb.sv
// lplpm_top_tb: self-checking bench for the low-power state tracker
// assumes: lplpm_ctrl_model drives every link pin but bank_addr; clk runs at 10 MHz
`timescale 1ns/1ps
module lplpm_top_tb;
   // ****************************************************************
   // clock, reset, partner and device
   // ****************************************************************
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic clk_true, clk_comp, cke, cs_n, ras_n, cas_n, we_n, all_bank;
   logic [1:0] bank_addr = 2'h0;
   logic [2:0] pasr_select = 3'h1;
   logic [1:0] temp_sensor = 2'h2;
   logic [2:0] lp_state;
   logic bufs_on, data_valid, init_req, refresh_pulse, exit_busy, cmd_violation;
   logic viol_seen = 1'b0;
   logic pulse_seen = 1'b0;
   int miscompares = 0;
   int tests_run = 0;

   always #50 clk = ~clk;

   lplpm_ctrl_model i_ctl (.clk(clk), .diff_clock_true(clk_true), .diff_clock_comp(clk_comp),
      .clock_enable_pin(cke), .chip_select_n(cs_n), .row_strobe_n(ras_n),
      .column_strobe_n(cas_n), .write_enable_n(we_n), .precharge_all_addr_bit(all_bank));

   lplpm_top i_dut (.clk(clk), .reset_n(reset_n), .diff_clock_true(clk_true),
      .diff_clock_comp(clk_comp), .clock_enable_pin(cke), .chip_select_n(cs_n),
      .row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_enable_n(we_n),
      .precharge_all_addr_bit(all_bank), .bank_addr(bank_addr), .pasr_select(pasr_select),
      .temp_sensor(temp_sensor), .lp_state(lp_state), .input_buffers_on(bufs_on),
      .data_valid(data_valid), .init_required(init_req), .refresh_pulse(refresh_pulse),
      .exit_busy(exit_busy), .cmd_violation(cmd_violation));

   // sticky copies of the one-cycle pulses, so a check may come later
   always @(posedge clk) begin
      if (cmd_violation === 1'b1) viol_seen <= 1'b1;
      if (refresh_pulse === 1'b1) pulse_seen <= 1'b1;
   end

   // ****************************************************************
   // compare and helper tasks
   // ****************************************************************
   task automatic check_state(input logic [2:0] got, input logic [2:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected state at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_state

   task automatic check_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_flag

   // one link period, then one more core clock so the answer has landed
   task automatic step(input logic [3:0] cmd, input logic ck_en, input logic all_bit,
      input int half = 4);
      i_ctl.drive(cmd, ck_en, all_bit, half);
      @(posedge clk);
      #5;
   endtask : step

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic test_reset;
      check_state(lp_state, 3'h0);
      check_flag(bufs_on, 1'b1);
      check_flag(init_req, 1'b1);
      check_flag(data_valid, 1'b0);
      check_flag(exit_busy, 1'b0);
      step(lplpm_pkg::CMD_MODE, 1'b1, 1'b0);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      check_flag(init_req, 1'b0);
      check_flag(data_valid, 1'b1);
      $display("test reset and init done");
   endtask : test_reset

   // precharge power-down from idle, active power-down with a row open
   task automatic test_power_down;
      step(lplpm_pkg::CMD_REFRESH, 1'b1, 1'b0);
      check_state(lp_state, 3'h0);
      step(lplpm_pkg::CMD_NOP, 1'b0, 1'b0);
      check_state(lp_state, 3'h3);
      check_flag(bufs_on, 1'b0);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      check_state(lp_state, 3'h0);
      check_flag(bufs_on, 1'b1);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      step(lplpm_pkg::CMD_ACTIVE, 1'b1, 1'b0);
      check_state(lp_state, 3'h1);
      step(lplpm_pkg::CMD_NOP, 1'b0, 1'b0);
      check_state(lp_state, 3'h4);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      check_state(lp_state, 3'h1);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      step(lplpm_pkg::CMD_PRECHARGE, 1'b1, 1'b1);
      check_state(lp_state, 3'h0);
      // link clock doubled for a while: commands still land on its edges
      step(lplpm_pkg::CMD_ACTIVE, 1'b1, 1'b0, 2);
      check_state(lp_state, 3'h1);
      step(lplpm_pkg::CMD_PRECHARGE, 1'b1, 1'b1, 2);
      check_state(lp_state, 3'h0);
      $display("test power-down done");
   endtask : test_power_down

   // entry, a command that must be ignored, a clockless stretch, exit
   task automatic test_self_refresh;
      int n;
      step(lplpm_pkg::CMD_REFRESH, 1'b0, 1'b0);
      check_state(lp_state, 3'h2);
      check_flag(bufs_on, 1'b0);
      step(lplpm_pkg::CMD_ACTIVE, 1'b0, 1'b0);
      check_state(lp_state, 3'h2);
      n = 0;
      while (pulse_seen !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      check_flag(pulse_seen, 1'b1);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      check_state(lp_state, 3'h0);
      check_flag(exit_busy, 1'b1);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      check_flag(exit_busy, 1'b0);
      check_flag(init_req, 1'b0);
      $display("test self refresh done");
   endtask : test_self_refresh

   // parked clock, then an ACTIVE instead of a NOP on the very first restart edge
   task automatic test_clock_stop;
      check_flag(viol_seen, 1'b0);
      i_ctl.halt(20);
      check_state(lp_state, 3'h6);
      step(lplpm_pkg::CMD_ACTIVE, 1'b1, 1'b0);
      check_flag(viol_seen, 1'b1);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      step(lplpm_pkg::CMD_PRECHARGE, 1'b1, 1'b1);
      check_state(lp_state, 3'h0);
      $display("test clock stop done");
   endtask : test_clock_stop

   task automatic test_deep_sleep;
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      step(lplpm_pkg::CMD_DEEP, 1'b0, 1'b0);
      check_state(lp_state, 3'h5);
      check_flag(data_valid, 1'b0);
      step(lplpm_pkg::CMD_NOP, 1'b0, 1'b0);
      check_state(lp_state, 3'h5);
      step(lplpm_pkg::CMD_NOP, 1'b1, 1'b0);
      check_state(lp_state, 3'h0);
      check_flag(init_req, 1'b1);
      $display("test deep sleep done");
   endtask : test_deep_sleep

   // ****************************************************************
   // main sequence and hang guard
   // ****************************************************************
   initial begin
      repeat (5) @(posedge clk);
      #5;
      reset_n = 1'b1;
      test_reset();
      test_power_down();
      test_self_refresh();
      test_clock_stop();
      test_deep_sleep();
      tally_and_finish();
   end

   // a stuck run is cut off at 40000 core clocks, far above a normal run
   initial begin
      repeat (40000) @(posedge clk);
      miscompares++;
      $display("run limit reached at %0t", $time);
      tally_and_finish();
   end
endmodule : lplpm_top_tb
